// file: bench/fsw_spi_master.sv
`timescale 1ns/1ps

// Serial bus master model that issues framed instructions in mode 0.
module fsw_spi_master (
  output logic      sck,
  output logic      csN,
  output logic      si,
  input  wire logic so,
  input  wire logic soOe
);

  initial begin
    sck = 1'b0;
    csN = 1'b0;
    si  = 1'b0;
    // A clean rising edge on select clears the link logic before the first frame.
    #1;
    csN = 1'b1;
  end

  // Sends n bits MSB first; returns the last eight bits seen on the output line.
  task automatic xfer(input logic [63:0] bitsOut, input int n, output logic [7:0] rd);
    rd  = 8'h00;
    csN = 1'b0;
    for (int i = 0; i < n; i++) begin
      si = bitsOut[n - 1 - i];
      #6;
      sck = 1'b1;
      rd = {rd[6:0], (soOe === 1'b1) ? so : 1'bx};
      #6;
      sck = 1'b0;
    end
    #6;
    csN = 1'b1;
    si = ~si;
    #20;
  endtask : xfer

endmodule : fsw_spi_master

// file: bench/tb_flash_status_write_gate.sv
`timescale 1ns/1ps

module tb_flash_status_write_gate;

  logic                 core_clk;
  logic                 rst;
  logic                 wpN;
  logic                 sck;
  logic                 csN;
  logic                 si;
  logic                 soOut;
  logic                 soOe;
  fsw_pkg::fsw_status_t statusWord;
  logic                 opStart;
  fsw_pkg::fsw_op_t     opKind;
  fsw_pkg::fsw_op_t     lastKind;
  logic [12:0]          opSector;
  logic [8:0]           opBlock;
  logic [7:0]           rdVal;
  int                   starts;
  int                   mark;
  int                   fails;
  int                   totalChecks;

  fsw_status_gate #(
    .PROG_CYCLES   (100),
    .ERASE_CYCLES  (60),
    .CHIP_CYCLES   (120),
    .STATUS_CYCLES (150)
  ) u_dut (
    .core_clk   (core_clk),
    .rst        (rst),
    .sck        (sck),
    .csN        (csN),
    .si         (si),
    .wpN        (wpN),
    .soOut      (soOut),
    .soOe       (soOe),
    .statusWord (statusWord),
    .opStart    (opStart),
    .opKind     (opKind),
    .opSector   (opSector),
    .opBlock    (opBlock)
  );

  fsw_spi_master u_master (
    .sck  (sck),
    .csN  (csN),
    .si   (si),
    .so   (soOut),
    .soOe (soOe)
  );

  initial begin
    core_clk = 1'b0;
    rst      = 1'b1;
    wpN      = 1'b1;
    starts   = 0;
    lastKind = fsw_pkg::FSW_OP_NONE;
  end

  always #2.5 core_clk = ~core_clk;

  // Counts started operations and keeps the kind of the last one.
  always @(posedge core_clk) begin
    if (opStart === 1'b1) begin
      starts <= starts + 1;
      lastKind <= opKind;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic frame(input logic [63:0] b, input int n);
    logic [7:0] d;
    @(negedge core_clk);
    u_master.xfer(b, n, d);
    repeat (10) @(negedge core_clk);
  endtask : frame

  task automatic rd_status(output logic [7:0] v);
    @(negedge core_clk);
    u_master.xfer({48'h0000_0000_0000, 16'h0500}, 16, v);
    repeat (10) @(negedge core_clk);
  endtask : rd_status

  task automatic wait_idle();
    int k;
    k = 0;
    while (statusWord.busy_flag !== 1'b0 && k < 1000) begin
      @(negedge core_clk);
      k++;
    end
    check("busy wait", 32'(k < 1000), 32'h0000_0001);
    repeat (4) @(negedge core_clk);
  endtask : wait_idle

  initial begin
    #400000;
    fails++;
    close_out();
  end

  initial begin
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    repeat (3) @(negedge core_clk);
    check("status reset", statusWord, 32'h0000_0000);
    rd_status(rdVal);
    check("serial status reset", rdVal, 32'h0000_0000);
    frame({48'h0, 16'h015C}, 16);
    check("write without latch", starts, 32'h0000_0000);
    frame(64'h0000_0000_0000_0006, 8);
    check("latch set", statusWord, 32'h0000_0002);
    frame(64'h0000_0000_0000_0004, 8);
    check("latch clear", statusWord, 32'h0000_0000);
    frame(64'h0000_0000_0000_0006, 8);
    frame({48'h0, 16'h015F}, 16);
    check("status write kind", lastKind, fsw_pkg::FSW_OP_STATUS);
    check("busy during write", statusWord, 32'h0000_0003);
    frame(64'h0000_0000_0000_0004, 8);
    check("clear ignored busy", statusWord, 32'h0000_0003);
    rd_status(rdVal);
    check("read while busy", rdVal, 32'h0000_0003);
    wait_idle();
    check("status written", statusWord, 32'h0000_005C);
    rd_status(rdVal);
    check("serial status", rdVal, 32'h0000_005C);
    frame(64'h0000_0000_0000_0006, 8);
    frame({32'h0, 32'h2012_3456}, 32);
    check("erase kind", lastKind, fsw_pkg::FSW_OP_ERASE);
    check("erase sector", opSector, 32'h0000_0123);
    check("erase block", opBlock, 32'h0000_0012);
    check("busy erase", statusWord, 32'h0000_005F);
    wait_idle();
    check("erase done", statusWord, 32'h0000_005C);
    frame(64'h0000_0000_0000_0006, 8);
    frame({24'h00_0000, 40'h02_0001_00A5}, 40);
    check("program kind", lastKind, fsw_pkg::FSW_OP_PROG);
    frame(64'h0000_0000_0000_0075, 8);
    check("suspended", statusWord, 32'h0000_005E);
    frame(64'h0000_0000_0000_007A, 8);
    wait_idle();
    check("program done", statusWord, 32'h0000_005C);
    frame(64'h0000_0000_0000_0006, 8);
    frame({48'h0, 16'h01DC}, 16);
    wait_idle();
    check("lock written", statusWord, 32'h0000_00DC);
    @(negedge core_clk);
    wpN = 1'b0;
    frame(64'h0000_0000_0000_0006, 8);
    mark = starts;
    frame({48'h0, 16'h0100}, 16);
    check("locked write start", starts, mark);
    check("locked status", statusWord, 32'h0000_00DE);
    @(negedge core_clk);
    wpN = 1'b1;
    repeat (4) @(negedge core_clk);
    frame({48'h0, 16'h0100}, 16);
    wait_idle();
    check("unlocked write", statusWord, 32'h0000_0000);
    mark = starts;
    frame({48'h0, 16'hC000}, 16);
    check("volatile write", starts, mark + 1);
    check("volatile latch", statusWord, 32'h0000_0000);
    frame(64'h0000_0000_0000_0006, 8);
    frame({24'h00_0000, 40'hDC_01AB_CDEF}, 40);
    check("erase4 kind", lastKind, fsw_pkg::FSW_OP_ERASE);
    check("erase4 sector", opSector, 32'h0000_1ABC);
    check("erase4 block", opBlock, 32'h0000_01AB);
    wait_idle();
    check("erase4 done", statusWord, 32'h0000_0000);
    frame(64'h0000_0000_0000_0006, 8);
    mark = starts;
    frame(64'h0000_0000_0000_00C7, 8);
    check("chip erase start", starts, mark + 1);
    check("chip erase kind", lastKind, fsw_pkg::FSW_OP_ERASE);
    check("chip erase busy", statusWord, 32'h0000_0003);
    frame(64'h0000_0000_0000_0066, 8);
    frame(64'h0000_0000_0000_0099, 8);
    check("reset while busy", statusWord, 32'h0000_0000);
    close_out();
  end

endmodule : tb_flash_status_write_gate

// file: shared/fsw_cfg.svh
`ifndef FSW_CFG_SVH
`define FSW_CFG_SVH

`define FSW_BIT_BUSY      0
`define FSW_BIT_LATCH     1
`define FSW_BIT_PROT_LO   2
`define FSW_BIT_PROT_HI   5
`define FSW_BIT_QUAD      6
`define FSW_BIT_LOCK      7
`define FSW_STATUS_RESET  8'h00

`define FSW_CMD_WRITE_STATUS  8'h01
`define FSW_CMD_PROG          8'h02
`define FSW_CMD_CLEAR_LATCH   8'h04
`define FSW_CMD_READ_STATUS   8'h05
`define FSW_CMD_SET_LATCH     8'h06
`define FSW_CMD_PROG4         8'h12
`define FSW_CMD_SECT_ERASE    8'h20
`define FSW_CMD_SECT_ERASE4   8'h21
`define FSW_CMD_SECT_ERASE_B  8'hD7
`define FSW_CMD_BLK32_ERASE   8'h52
`define FSW_CMD_BLK64_ERASE   8'hD8
`define FSW_CMD_BLK64_ERASE4  8'hDC
`define FSW_CMD_CHIP_ERASE    8'hC7
`define FSW_CMD_CHIP_ERASE_B  8'h60
`define FSW_CMD_SUSPEND       8'h75
`define FSW_CMD_RESUME        8'h7A
`define FSW_CMD_RESET_ARM     8'h66
`define FSW_CMD_RESET         8'h99
`define FSW_CMD_READ_FUNC     8'h48
`define FSW_CMD_READ_EXT      8'h81
`define FSW_CMD_SET_VOLATILE  8'hC0

`define FSW_CLK_NS        5
`define FSW_PROG_NS       4000
`define FSW_ERASE_NS      20000
`define FSW_CHIP_NS       80000
`define FSW_STATUS_NS     10000
`define FSW_PROG_CYC      ((`FSW_PROG_NS + `FSW_CLK_NS - 1) / `FSW_CLK_NS)
`define FSW_ERASE_CYC     ((`FSW_ERASE_NS + `FSW_CLK_NS - 1) / `FSW_CLK_NS)
`define FSW_CHIP_CYC      ((`FSW_CHIP_NS + `FSW_CLK_NS - 1) / `FSW_CLK_NS)
`define FSW_STATUS_CYC    ((`FSW_STATUS_NS + `FSW_CLK_NS - 1) / `FSW_CLK_NS)

`define FSW_SECTOR_SHIFT  12
`define FSW_BLOCK_SHIFT   16
`define FSW_ADDR_W        25

`endif

// file: shared/fsw_pkg.sv
package fsw_pkg;

  typedef enum logic [1:0] {
    FSW_IDLE = 2'b00,
    FSW_BUSY = 2'b01,
    FSW_SUSP = 2'b10
  } fsw_state_t;

  typedef enum logic [1:0] {
    FSW_OP_NONE   = 2'b00,
    FSW_OP_PROG   = 2'b01,
    FSW_OP_ERASE  = 2'b10,
    FSW_OP_STATUS = 2'b11
  } fsw_op_t;

  typedef struct packed {
    logic       status_write_lock;
    logic       quad_enable_bit;
    logic [3:0] protect;
    logic       write_latch;
    logic       busy_flag;
  } fsw_status_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  data;
    logic [23:0] addr3;
    logic [31:0] addr4;
    logic [5:0]  bits;
  } fsw_link_t;

endpackage : fsw_pkg

// file: verilog/fsw_status_gate.sv
`timescale 1ns/1ps
`include "fsw_cfg.svh"

module fsw_status_gate #(
  parameter int PROG_CYCLES   = `FSW_PROG_CYC,
  parameter int ERASE_CYCLES  = `FSW_ERASE_CYC,
  parameter int CHIP_CYCLES   = `FSW_CHIP_CYC,
  parameter int STATUS_CYCLES = `FSW_STATUS_CYC
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   sck,
  input  wire logic                   csN,
  input  wire logic                   si,
  input  wire logic                   wpN,
  output logic                        soOut,
  output logic                        soOe,
  output fsw_pkg::fsw_status_t        statusWord,
  output logic                        opStart,
  output fsw_pkg::fsw_op_t            opKind,
  output logic [12:0]                 opSector,
  output logic [8:0]                  opBlock
);

  fsw_pkg::fsw_link_t   lnk;
  logic [31:0]          shiftIn;
  logic                 newFrame;
  logic                 lnkTgl = 1'b0;
  logic [5:0]           idx;
  fsw_pkg::fsw_status_t statMeta;
  fsw_pkg::fsw_status_t statLink;

  // Link side: a frame starts when the first serial edge follows chip select.
  always_ff @(posedge sck or posedge csN) begin
    if (csN) begin
      newFrame <= 1'b1;
    end else begin
      newFrame <= 1'b0;
    end
  end

  assign idx = newFrame ? 6'd0 : lnk.bits;

  always_ff @(posedge sck) begin
    shiftIn <= {shiftIn[30:0], si};
    lnk.bits <= (idx == 6'd63) ? 6'd56 : idx + 6'd1;
    if (newFrame) begin
      lnkTgl <= ~lnkTgl;
    end
    if (idx == 6'd7) begin
      lnk.opcode <= {shiftIn[6:0], si};
    end
    if (idx == 6'd15) begin
      lnk.data <= {shiftIn[6:0], si};
    end
    if (idx == 6'd31) begin
      lnk.addr3 <= {shiftIn[22:0], si};
    end
    if (idx == 6'd39) begin
      lnk.addr4 <= {shiftIn[30:0], si};
    end
  end

  always_ff @(posedge sck) begin
    statMeta <= statusWord;
    statLink <= statMeta;
  end

  always_ff @(negedge sck or posedge csN) begin
    if (csN) begin
      soOe  <= 1'b0;
      soOut <= 1'b0;
    end else begin
      soOe  <= !newFrame && lnk.bits >= 6'd8 && lnk.opcode == `FSW_CMD_READ_STATUS;
      soOut <= statLink[3'd7 - lnk.bits[2:0]];
    end
  end

  logic                  csSync1;
  logic                  csSync2;
  logic                  csPrev;
  logic                  tglSync1;
  logic                  tglSync2;
  logic                  frameSeen;
  logic                  wpSync1;
  logic                  wpSync2;
  logic                  exec;
  logic [7:0]            op;
  logic [5:0]            n;
  logic                  lenOk;
  fsw_pkg::fsw_state_t   state;
  fsw_pkg::fsw_op_t      kind;
  logic [23:0]           timer;
  logic                  latch;
  logic [5:0]            nvBits;
  logic [5:0]            pendNv;
  logic                  rstArmed;
  logic                  isProg;
  logic                  isErase;
  logic                  isChip;
  logic                  isWrsr;
  logic                  writeOk;
  logic                  statusLocked;
  logic                  startProg;
  logic                  startErase;
  logic                  startWrsr;
  logic                  swReset;
  logic                  suspendCmd;
  logic                  resumeCmd;
  logic                  done;
  logic                  wide;
  logic [`FSW_ADDR_W-1:0] opAddr;
  logic [23:0]           opCycles;

  always_ff @(posedge core_clk) begin
    csSync1  <= csN;
    csSync2  <= csSync1;
    csPrev   <= csSync2;
    tglSync1 <= lnkTgl;
    tglSync2 <= tglSync1;
    wpSync1  <= wpN;
    wpSync2  <= wpSync1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      frameSeen <= tglSync2;
    end else if (csSync2 && !csPrev) begin
      frameSeen <= tglSync2;
    end
  end

  // Link captures are steady once chip select is seen high again.
  assign exec  = csSync2 && !csPrev && (tglSync2 != frameSeen);
  assign op    = lnk.opcode;
  assign n     = lnk.bits;
  assign lenOk = (n[2:0] == 3'd0) && (n != 6'd0);

  assign isProg  = (op == `FSW_CMD_PROG && n >= 6'd40) || (op == `FSW_CMD_PROG4 && n >= 6'd48);
  assign isChip  = (op == `FSW_CMD_CHIP_ERASE || op == `FSW_CMD_CHIP_ERASE_B) && n == 6'd8
                   && statusWord.protect == 4'h0;
  assign isErase = isChip
                   || ((op == `FSW_CMD_SECT_ERASE || op == `FSW_CMD_SECT_ERASE_B
                        || op == `FSW_CMD_BLK32_ERASE || op == `FSW_CMD_BLK64_ERASE) && n == 6'd32)
                   || ((op == `FSW_CMD_SECT_ERASE4 || op == `FSW_CMD_BLK64_ERASE4) && n == 6'd40);
  assign isWrsr  = op == `FSW_CMD_WRITE_STATUS && n == 6'd16;
  assign writeOk = exec && latch && state == fsw_pkg::FSW_IDLE;
  assign statusLocked = nvBits[5] && !wpSync2;
  assign startProg  = writeOk && isProg;
  assign startErase = writeOk && isErase;
  assign startWrsr  = writeOk && isWrsr && !statusLocked;
  assign swReset    = exec && op == `FSW_CMD_RESET && n == 6'd8 && rstArmed;
  assign suspendCmd = exec && op == `FSW_CMD_SUSPEND && lenOk && state == fsw_pkg::FSW_BUSY
                      && (kind == fsw_pkg::FSW_OP_PROG || kind == fsw_pkg::FSW_OP_ERASE);
  assign resumeCmd  = exec && op == `FSW_CMD_RESUME && lenOk && state == fsw_pkg::FSW_SUSP;
  assign done = state == fsw_pkg::FSW_BUSY && timer == 24'h00_0000 && !swReset && !suspendCmd;

  assign wide   = op == `FSW_CMD_PROG4 || op == `FSW_CMD_SECT_ERASE4 || op == `FSW_CMD_BLK64_ERASE4;
  assign opAddr = wide ? lnk.addr4[`FSW_ADDR_W-1:0] : {1'b0, lnk.addr3};

  always_comb begin
    if (startWrsr) begin
      opCycles = 24'(STATUS_CYCLES);
    end else if (isProg) begin
      opCycles = 24'(PROG_CYCLES);
    end else if (isChip) begin
      opCycles = 24'(CHIP_CYCLES);
    end else begin
      opCycles = 24'(ERASE_CYCLES);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= fsw_pkg::FSW_IDLE;
      timer <= 24'h00_0000;
      kind  <= fsw_pkg::FSW_OP_NONE;
    end else begin
      case (state)
        fsw_pkg::FSW_IDLE: begin
          if (startProg || startErase || startWrsr) begin
            state <= fsw_pkg::FSW_BUSY;
            timer <= opCycles;
            kind  <= startProg ? fsw_pkg::FSW_OP_PROG
                   : startErase ? fsw_pkg::FSW_OP_ERASE : fsw_pkg::FSW_OP_STATUS;
          end
        end
        fsw_pkg::FSW_BUSY: begin
          if (swReset) begin
            state <= fsw_pkg::FSW_IDLE;
          end else if (suspendCmd) begin
            state <= fsw_pkg::FSW_SUSP;
          end else if (done) begin
            state <= fsw_pkg::FSW_IDLE;
          end else begin
            timer <= timer - 24'h00_0001;
          end
        end
        fsw_pkg::FSW_SUSP: begin
          if (swReset) begin
            state <= fsw_pkg::FSW_IDLE;
          end else if (resumeCmd) begin
            state <= fsw_pkg::FSW_BUSY;
          end
        end
        default: begin
          state <= fsw_pkg::FSW_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rstArmed <= 1'b0;
    end else if (exec) begin
      rstArmed <= op == `FSW_CMD_RESET_ARM && n == 6'd8;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      latch <= 1'b0;
    end else if (swReset || done) begin
      latch <= 1'b0;
    end else if (exec && n == 6'd8 && state != fsw_pkg::FSW_BUSY && op == `FSW_CMD_CLEAR_LATCH) begin
      latch <= 1'b0;
    end else if (exec && n == 6'd8 && state != fsw_pkg::FSW_BUSY && op == `FSW_CMD_SET_LATCH) begin
      latch <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      nvBits <= 6'(`FSW_STATUS_RESET >> `FSW_BIT_PROT_LO);
      pendNv <= 6'h00;
    end else begin
      if (startWrsr) begin
        pendNv <= lnk.data[`FSW_BIT_LOCK:`FSW_BIT_PROT_LO];
      end
      if (done && kind == fsw_pkg::FSW_OP_STATUS) begin
        nvBits <= pendNv;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      statusWord <= `FSW_STATUS_RESET;
    end else begin
      statusWord <= {nvBits, latch, state == fsw_pkg::FSW_BUSY};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      opStart  <= 1'b0;
      opKind   <= fsw_pkg::FSW_OP_NONE;
      opSector <= 13'h0000;
      opBlock  <= 9'h000;
    end else begin
      opStart <= startProg || startErase || startWrsr
                 || (exec && op == `FSW_CMD_SET_VOLATILE && n == 6'd16 && state == fsw_pkg::FSW_IDLE);
      if (startProg || startErase || startWrsr) begin
        opKind   <= startProg ? fsw_pkg::FSW_OP_PROG
                  : startErase ? fsw_pkg::FSW_OP_ERASE : fsw_pkg::FSW_OP_STATUS;
        opSector <= opAddr[`FSW_ADDR_W-1:`FSW_SECTOR_SHIFT];
        opBlock  <= opAddr[`FSW_ADDR_W-1:`FSW_BLOCK_SHIFT];
      end else if (opStart) begin
        opKind <= fsw_pkg::FSW_OP_NONE;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_write_status_cmd_keeps_latch: assert property (startWrsr |=> latch == $past(latch))
    else $error("write-status changed the write latch");
  a_latch_set_cmd: assert property (exec && n == 6'd8 && op == `FSW_CMD_SET_LATCH
    && state != fsw_pkg::FSW_BUSY && !swReset |=> latch ##1 statusWord.write_latch)
    else $error("set-latch did not set the latch");
  a_done_clears_flags: assert property (done |=> !latch ##1 !statusWord.busy_flag
    && !statusWord.write_latch)
    else $error("completion left busy or latch set");
  a_no_latch_gate: assert property (exec && !latch && (isProg || isErase || isWrsr)
    |=> !opStart)
    else $error("write started without the latch");
  a_busy_ignores_cmds: assert property (exec && state == fsw_pkg::FSW_BUSY
    && op == `FSW_CMD_CLEAR_LATCH && !done |=> latch == $past(latch))
    else $error("command acted while busy");
  a_lock_blocks_write_status_cmd: assert property (exec && isWrsr && statusLocked |=> !opStart)
    else $error("locked status word accepted a write");
  a_nv_update_done: assert property (done && kind == fsw_pkg::FSW_OP_STATUS
    |=> nvBits == $past(pendNv) ##1 statusWord[7:2] == $past(nvBits))
    else $error("status write did not land");
  a_suspend_accept: assert property (suspendCmd |=> state == fsw_pkg::FSW_SUSP
    ##1 !statusWord.busy_flag)
    else $error("suspend not taken");
  a_busy_out_tracks: assert property (state == fsw_pkg::FSW_BUSY |=> statusWord.busy_flag)
    else $error("busy flag low during operation");

  c_status_written: cover property (done && kind == fsw_pkg::FSW_OP_STATUS);
  c_erase_started: cover property (startErase);
  c_suspend_resume: cover property (suspendCmd ##[1:1000] resumeCmd);

endmodule : fsw_status_gate
